// >>> rtl/fpma_map.vh
// Constants for the flash program memory access port: register offsets,
// field positions, geometry and AXI response codes.
// Assumes inclusion by bare name from the port's design files.
`ifndef FPMA_MAP_VH
`define FPMA_MAP_VH

// Register byte offsets on the AXI4-Lite slave
`define FPMA_OFF_ADDR_LOW   8'h00
`define FPMA_OFF_ADDR_HIGH  8'h04
`define FPMA_OFF_DATA_LOW   8'h08
`define FPMA_OFF_DATA_HIGH  8'h0C
`define FPMA_OFF_CONTROL    8'h10
`define FPMA_OFF_PROTECT    8'h14
`define FPMA_OFF_LATCH_CNT  8'h18

// Control register bit positions
`define FPMA_CTL_READ       0
`define FPMA_CTL_WRITE      1
`define FPMA_CTL_ERASE      2
`define FPMA_CTL_WREN       3
`define FPMA_CTL_REFUSED    4
`define FPMA_CTL_BUSY       5
`define FPMA_CTL_PROG_SEL   6
`define FPMA_CTL_CFG_SEL    7

// Geometry
`define FPMA_WORD_W         14
`define FPMA_ADDR_W         13
`define FPMA_ROW_WORDS      32
`define FPMA_ROW_BITS       5
`define FPMA_ERASED_WORD    14'h3FFF

// AXI responses
`define FPMA_RESP_OKAY      2'b00
`define FPMA_RESP_SLVERR    2'b10

`endif

// >>> rtl/fpma_mem.v
// Program flash array model: one word per address, registered read data.
// Assumes a single clock; one read and one write per cycle.
`timescale 1ns/100ps

module fpma_mem
#(
  parameter AW = 13,
  parameter DW = 14
)
(
  input  wire          clk,      // Clock
  input  wire          wrEn,     // Write strobe
  input  wire [AW-1:0] wrAddr,   // Write address
  input  wire [DW-1:0] wrData,   // Write data
  input  wire [AW-1:0] rdAddr,   // Read address
  output reg  [DW-1:0] rdData_q  // Registered read data
);

  reg [DW-1:0] memArray [0:(1<<AW)-1];

  // Write and registered read
  always @(posedge clk)
  begin
    if (wrEn)
      memArray[wrAddr] <= wrData;
    rdData_q <= memArray[rdAddr];
  end

endmodule // fpma_mem

// >>> rtl/fpma_top.v
// Flash program memory access port with AXI4-Lite register slave.
// Assumes AXI inputs synchronous to ref_clk; write-protect field static.
//
// Functional notes
// RULE_01: Flash is rows of 32 words; a whole row is the erase unit.
// RULE_02: Writes or erases inside write-protected segments are refused.
// RULE_03: Row data is staged first in 14-bit write latches, one per word.
// RULE_04: Latches are loaded only by writing the data register pair.
// RULE_05: 32 latches cover a block whose low five address bits are zero.
// RULE_06: Software refills latches and reprograms until the row is done.
// RULE_07: Software loads address, clears config select, sets program select, strobes read.
// RULE_08: The second cycle after the read strobe is stolen for the flash.
// RULE_09: Fetched word lands in the data pair right after the stolen cycle.
// RULE_10: Data pair holds the word until another read or a software write.
// RULE_11: Software follows the read strobe with two no-operation instructions.
// RULE_12: Reads work whatever the code-protect setting is.
// RULE_13: Software saves a whole row in RAM before a partial rewrite.
// RULE_14: Software may read back written locations to verify them.
// RULE_15: Hardware clears the read strobe once the word is in the data pair.
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`include "fpma_map.vh"

module fpma_top
#(
  parameter AW = `FPMA_ADDR_W
)
(
  input  wire        ref_clk,       // Instruction clock
  input  wire        reset_n,       // Async reset, active low
  input  wire [1:0]  writeProtect,  // Write-protect field
  input  wire        codeProtect,   // Code protect, no effect on reads
  input  wire [7:0]  s_axi_awaddr,  // Write address
  input  wire        s_axi_awvalid, // Write address valid
  output reg         s_axi_awready, // Write address ready
  input  wire [31:0] s_axi_wdata,   // Write data
  input  wire [3:0]  s_axi_wstrb,   // Write strobes
  input  wire        s_axi_wvalid,  // Write data valid
  output reg         s_axi_wready,  // Write data ready
  output reg  [1:0]  s_axi_bresp,   // Write response
  output reg         s_axi_bvalid,  // Write response valid
  input  wire        s_axi_bready,  // Write response ready
  input  wire [7:0]  s_axi_araddr,  // Read address
  input  wire        s_axi_arvalid, // Read address valid
  output reg         s_axi_arready, // Read address ready
  output reg  [31:0] s_axi_rdata,   // Read data
  output reg  [1:0]  s_axi_rresp,   // Read response
  output reg         s_axi_rvalid,  // Read data valid
  input  wire        s_axi_rready,  // Read data ready
  output reg         stallCycle_q   // Core must skip this instruction slot
);

  //--------------------------------------------------------------------
  // Sequencer states
  //--------------------------------------------------------------------
  localparam [4:0] ST_IDLE  = 5'b00001;
  localparam [4:0] ST_WAIT  = 5'b00010;
  localparam [4:0] ST_STEAL = 5'b00100;
  localparam [4:0] ST_PROG  = 5'b01000;
  localparam [4:0] ST_ERASE = 5'b10000;

  reg [4:0]            state_q;
  reg [7:0]            addrLow_q;
  reg [AW-9:0]         addrHigh_q;
  reg [7:0]            dataLow_q;
  reg [5:0]            dataHigh_q;
  reg                  readStb_q, writeStb_q, eraseStb_q, wren_q;
  reg                  refused_q, progSel_q, cfgSel_q;
  reg [`FPMA_ROW_BITS:0] latchCnt_q;
  reg [`FPMA_ROW_BITS-1:0] walk_q;
  reg [`FPMA_WORD_W-1:0] latch_q [0:`FPMA_ROW_WORDS-1];
  reg [`FPMA_ROW_WORDS-1:0] latchValid_q;
  reg                  awHeld_q, wHeld_q;
  reg [7:0]            awAddr_q;
  reg [31:0]           wData_q;
  reg [3:0]            wStrb_q;

  wire [AW-1:0] fullAddr = {addrHigh_q, addrLow_q};
  wire [AW-1:0] rowBase  = {fullAddr[AW-1:`FPMA_ROW_BITS], {`FPMA_ROW_BITS{1'b0}}};
  wire [`FPMA_WORD_W-1:0] memRd;

  // Protected segment test: 11 none, 10 lower eighth, 01 lower half, 00 whole array
  function isProtected;
    input [1:0]    wp;
    input [AW-1:0] a;
    begin
      case (wp)
        2'b11:   isProtected = 1'b0;
        2'b10:   isProtected = (a[AW-1:AW-3] == 3'b000);
        2'b01:   isProtected = (a[AW-1] == 1'b0);
        default: isProtected = 1'b1;
      endcase
    end
  endfunction

  // Flash write port: program a latch word or erase a row word
  wire memWrEn = (state_q == ST_PROG && latchValid_q[walk_q]) || (state_q == ST_ERASE);
  wire [AW-1:0] walkAddr = rowBase | {{(AW-`FPMA_ROW_BITS){1'b0}}, walk_q};
  wire [`FPMA_WORD_W-1:0] memWrData = (state_q == ST_ERASE) ? `FPMA_ERASED_WORD
                                                             : latch_q[walk_q];

  fpma_mem #(.AW(AW), .DW(`FPMA_WORD_W)) uMem
  (
    .clk      (ref_clk),
    .wrEn     (memWrEn),
    .wrAddr   (walkAddr),
    .wrData   (memWrData),
    .rdAddr   (fullAddr),
    .rdData_q (memRd)
  );

  //--------------------------------------------------------------------
  // AXI write side
  //--------------------------------------------------------------------
  wire awGo = awHeld_q && wHeld_q && !s_axi_bvalid;
  wire [31:0] wm = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
  wire [31:0] wv = wData_q & wm;
  wire ctlHit   = awGo && awAddr_q == `FPMA_OFF_CONTROL;
  wire dLowHit  = awGo && awAddr_q == `FPMA_OFF_DATA_LOW  && wStrb_q[0];
  wire dHighHit = awGo && awAddr_q == `FPMA_OFF_DATA_HIGH && wStrb_q[0];
  wire mapped   = awAddr_q == `FPMA_OFF_ADDR_LOW || awAddr_q == `FPMA_OFF_ADDR_HIGH ||
                  awAddr_q == `FPMA_OFF_DATA_LOW || awAddr_q == `FPMA_OFF_DATA_HIGH ||
                  awAddr_q == `FPMA_OFF_CONTROL  || awAddr_q == `FPMA_OFF_PROTECT   ||
                  awAddr_q == `FPMA_OFF_LATCH_CNT;

  // Channel capture and response
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      awHeld_q <= 1'b0; wHeld_q <= 1'b0; awAddr_q <= 8'h00;
      wData_q <= 32'h0000_0000; wStrb_q <= 4'h0;
      s_axi_awready <= 1'b0; s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0; s_axi_bresp <= `FPMA_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !awHeld_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !wHeld_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_q <= 1'b1;
        awAddr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_q <= 1'b1; wData_q <= s_axi_wdata; wStrb_q <= s_axi_wstrb;
      end
      if (awGo)
      begin
        awHeld_q <= 1'b0; wHeld_q <= 1'b0; s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped ? `FPMA_RESP_OKAY : `FPMA_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  //--------------------------------------------------------------------
  // Registers, latches and sequencer
  //--------------------------------------------------------------------
  wire latchFull = latchCnt_q[`FPMA_ROW_BITS];
  integer i;

  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= ST_IDLE; addrLow_q <= 8'h00; addrHigh_q <= {(AW-8){1'b0}};
      dataLow_q <= 8'h00; dataHigh_q <= 6'h00;
      readStb_q <= 1'b0; writeStb_q <= 1'b0; eraseStb_q <= 1'b0; wren_q <= 1'b0;
      refused_q <= 1'b0; progSel_q <= 1'b0; cfgSel_q <= 1'b0;
      latchCnt_q <= {(`FPMA_ROW_BITS+1){1'b0}}; walk_q <= {`FPMA_ROW_BITS{1'b0}};
      latchValid_q <= {`FPMA_ROW_WORDS{1'b0}}; stallCycle_q <= 1'b0;
      for (i = 0; i < `FPMA_ROW_WORDS; i = i + 1)
        latch_q[i] <= {`FPMA_WORD_W{1'b0}};
    end
    else
    begin
      stallCycle_q <= 1'b0;
      // Software register writes
      if (awGo && awAddr_q == `FPMA_OFF_ADDR_LOW && wStrb_q[0])
        addrLow_q <= wv[7:0];
      if (awGo && awAddr_q == `FPMA_OFF_ADDR_HIGH && wStrb_q[0])
        addrHigh_q <= wv[AW-9:0];
      if (dLowHit)
        dataLow_q <= wv[7:0];                       // RULE_10
      if (dHighHit)
        dataHigh_q <= wv[5:0];                      // RULE_10
      // Latch load on data-high write, slot chosen by the low five address bits
      if (dHighHit && progSel_q && !cfgSel_q && !latchFull)
      begin
        latch_q[addrLow_q[`FPMA_ROW_BITS-1:0]] <= {wv[5:0], dataLow_q}; // RULE_03 RULE_04
        latchValid_q[addrLow_q[`FPMA_ROW_BITS-1:0]] <= 1'b1;           // RULE_05
        latchCnt_q <= latchCnt_q + 1'b1;
      end
      if (ctlHit && wStrb_q[0])
      begin
        progSel_q <= wv[`FPMA_CTL_PROG_SEL];
        cfgSel_q  <= wv[`FPMA_CTL_CFG_SEL];
        wren_q    <= wv[`FPMA_CTL_WREN];
        if (!wv[`FPMA_CTL_REFUSED])
          refused_q <= 1'b0;
        if (state_q == ST_IDLE)
        begin
          readStb_q  <= wv[`FPMA_CTL_READ] & wv[`FPMA_CTL_PROG_SEL]
                        & ~wv[`FPMA_CTL_CFG_SEL];
          writeStb_q <= wv[`FPMA_CTL_WRITE] & wv[`FPMA_CTL_WREN];
          eraseStb_q <= wv[`FPMA_CTL_ERASE] & wv[`FPMA_CTL_WREN];
        end
      end
      // Sequencer
      case (state_q)
        ST_IDLE:
        begin
          walk_q <= {`FPMA_ROW_BITS{1'b0}};
          if (readStb_q)
            state_q <= ST_WAIT;                     // RULE_12
          else if ((writeStb_q || eraseStb_q) && isProtected(writeProtect, rowBase))
          begin
            refused_q <= 1'b1;                      // RULE_02
            writeStb_q <= 1'b0;
            eraseStb_q <= 1'b0;
          end
          else if (eraseStb_q)
            state_q <= ST_ERASE;                    // RULE_01
          else if (writeStb_q)
            state_q <= ST_PROG;
        end
        ST_WAIT:
        begin
          state_q <= ST_STEAL;
          stallCycle_q <= 1'b1;                     // RULE_08
        end
        ST_STEAL:
        begin
          dataLow_q  <= memRd[7:0];                 // RULE_09
          dataHigh_q <= memRd[`FPMA_WORD_W-1:8];    // RULE_09
          readStb_q  <= 1'b0;                       // RULE_15
          state_q    <= ST_IDLE;
        end
        ST_PROG, ST_ERASE:
        begin
          walk_q <= walk_q + 1'b1;                  // RULE_01
          if (&walk_q)
          begin
            state_q <= ST_IDLE;
            writeStb_q <= 1'b0;
            eraseStb_q <= 1'b0;
            if (state_q == ST_PROG)
            begin
              latchValid_q <= {`FPMA_ROW_WORDS{1'b0}};
              latchCnt_q <= {(`FPMA_ROW_BITS+1){1'b0}};
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  //--------------------------------------------------------------------
  // AXI read side
  //--------------------------------------------------------------------
  reg [31:0] rdMux;
  reg        rdOk;

  // Read decode
  always @*
  begin
    rdOk = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `FPMA_OFF_ADDR_LOW:  rdMux = {24'h00_0000, addrLow_q};
      `FPMA_OFF_ADDR_HIGH: rdMux = {{(40-AW){1'b0}}, addrHigh_q};
      `FPMA_OFF_DATA_LOW:  rdMux = {24'h00_0000, dataLow_q};
      `FPMA_OFF_DATA_HIGH: rdMux = {26'h000_0000, dataHigh_q};
      `FPMA_OFF_CONTROL:   rdMux = {24'h00_0000, cfgSel_q, progSel_q, !state_q[0],
                                    refused_q, wren_q, eraseStb_q, writeStb_q, readStb_q};
      `FPMA_OFF_PROTECT:   rdMux = {29'h0000_0000, codeProtect, writeProtect};
      `FPMA_OFF_LATCH_CNT: rdMux = {26'h000_0000, latchCnt_q};
      default:
      begin
        rdMux = 32'h0000_0000;
        rdOk  = 1'b0;
      end
    endcase
  end

  // Read channel handshake
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_arready <= 1'b0; s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000; s_axi_rresp <= `FPMA_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdMux;
        s_axi_rresp  <= rdOk ? `FPMA_RESP_OKAY : `FPMA_RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // fpma_top

// >>> sim/fpma_core_model.sv
// Core model: counts the instruction slots the flash port steals.
// Assumes software fills the slots after a read strobe with no-ops.
`timescale 1ns/100ps

module fpma_core_model
(
  input  wire       ref_clk,      // Clock
  input  wire       reset_n,      // Reset, active low
  input  wire       stallCycle_q, // Stolen slot
  output reg  [7:0] stolen_q      // Stolen slot count
);
  // Skipped slot is a no-op, so only the count matters
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      stolen_q <= 8'h00;
    else if (stallCycle_q)
      stolen_q <= stolen_q + 8'h01;
  end
endmodule // fpma_core_model

// >>> sim/fpma_monitor.sv
// Checker for the flash access port: AXI answers and the stolen slot.
// Assumes binding to fpma_top; sees only its ports.
`timescale 1ns/100ps
`include "fpma_map.vh"

module fpma_monitor
(
  input wire        ref_clk,       // Clock
  input wire        reset_n,       // Reset, active low
  input wire        s_axi_awready, // AW ready
  input wire        s_axi_wready,  // W ready
  input wire        s_axi_bvalid,  // B valid
  input wire        s_axi_bready,  // B ready
  input wire [7:0]  s_axi_araddr,  // AR address
  input wire        s_axi_arvalid, // AR valid
  input wire        s_axi_arready, // AR ready
  input wire        s_axi_rvalid,  // R valid
  input wire        s_axi_rready,  // R ready
  input wire [31:0] s_axi_rdata,   // R data
  input wire [1:0]  s_axi_rresp,   // R response
  input wire        stallCycle_q   // Stolen slot
);
  reg  [2:0] sinceB_q;
  wire [2:0] sinceB_d;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // Cycles since the last write answer
  assign sinceB_d = s_axi_bvalid ? 3'h0 : ((sinceB_q == 3'h7) ? sinceB_q : sinceB_q + 3'h1);
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      sinceB_q <= 3'h7;
    else
      sinceB_q <= sinceB_d;
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_arTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_badAnswer;
    s_axi_rvalid && s_axi_rresp == `FPMA_RESP_SLVERR && s_axi_rdata == 32'h0000_0000;
  endsequence
  property p_stallPulse; stallCycle_q |=> !stallCycle_q; endproperty
  property p_stallCause; stallCycle_q |-> sinceB_q < 3'h5; endproperty
  property p_readAnswer; s_arTaken |-> ##[0:2] s_axi_rvalid; endproperty
  property p_unmapped; s_arTaken and s_axi_araddr[7:2] > 6'h06 |-> ##[0:2] s_badAnswer; endproperty
  property p_bOnce; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  property p_rOnce; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  property p_awPulse; s_axi_awready |=> !s_axi_awready; endproperty
  property p_wPulse; s_axi_wready |=> !s_axi_wready; endproperty

  a_stallPulse: assert property (p_stallPulse) else $error("stall longer than one slot");
  a_stallCause: assert property (p_stallCause) else $error("stall without control write");
  a_readAnswer: assert property (p_readAnswer) else $error("read answer late");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  a_bOnce: assert property (p_bOnce) else $error("write answer repeated");
  a_rOnce: assert property (p_rOnce) else $error("read answer repeated");
  a_awPulse: assert property (p_awPulse) else $error("awready held");
  a_wPulse: assert property (p_wPulse) else $error("wready held");
endmodule // fpma_monitor

// >>> sim/testbench.sv
// Bench for the flash access port: erase, program, protect, read.
// Assumes fpma_top with the core model watching the stolen slot.
`timescale 1ns/100ps
`include "fpma_map.vh"

module testbench;
  reg         ref_clk, reset_n, codeProtect, tA, tW, tB;
  reg  [1:0]  writeProtect, resp;
  reg  [7:0]  s_axi_awaddr, s_axi_araddr;
  reg  [31:0] s_axi_wdata, rdat;
  reg  [3:0]  s_axi_wstrb;
  reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire        stallCycle_q;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0]  stolen;
  integer     failCount, nTests, n, k;

  fpma_top fpma_top_i (.ref_clk(ref_clk), .reset_n(reset_n), .writeProtect(writeProtect),
    .codeProtect(codeProtect), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .stallCycle_q(stallCycle_q));
  fpma_core_model fpma_core_model_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .stallCycle_q(stallCycle_q), .stolen_q(stolen));

  // Clock, 50 ns period
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task printVerdict;
  begin
    if (failCount == 0 && nTests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  task chk(input [31:0] g, input [31:0] e);
  begin
    nTests = nTests + 1;
    if (g !== e)
    begin
      $display("Error at %0t: got %h expected %h", $time, g, e);
      failCount = failCount + 1;
    end
  end
  endtask
  task hang;
  begin
    failCount = failCount + 1;
    printVerdict;
  end
  endtask
  // Write: AW and W together, each released once taken
  task wr(input [7:0] a, input [31:0] d);
  begin
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tB = 1'b0;
    for (n = 0; n < 40 && !tB; n = n + 1)
    begin
      @(negedge ref_clk);
      tA = s_axi_awvalid && s_axi_awready;
      tW = s_axi_wvalid && s_axi_wready;
      tB = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge ref_clk);
      if (tA) s_axi_awvalid <= 1'b0;
      if (tW) s_axi_wvalid <= 1'b0;
      if (tB) s_axi_bready <= 1'b0;
    end
    if (!tB) hang;
  end
  endtask
  task rd(input [7:0] a);
  begin
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tB = 1'b0;
    for (n = 0; n < 40 && !tB; n = n + 1)
    begin
      @(negedge ref_clk);
      tA = s_axi_arvalid && s_axi_arready;
      tB = s_axi_rvalid;
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge ref_clk);
      if (tA) s_axi_arvalid <= 1'b0;
      if (tB) s_axi_rready <= 1'b0;
    end
    if (!tB) hang;
  end
  endtask
  task waitIdle;
  begin
    rdat = 32'h0000_0020;
    for (k = 0; k < 20 && rdat[5] !== 1'b0; k = k + 1)
      rd(`FPMA_OFF_CONTROL);
    if (rdat[5] !== 1'b0) hang;
  end
  endtask
  task setAddr(input [12:0] a);
  begin
    wr(`FPMA_OFF_ADDR_LOW, {24'h0, a[7:0]});
    wr(`FPMA_OFF_ADDR_HIGH, {27'h0, a[12:8]});
  end
  endtask
  task rdWord(input [12:0] a, input [13:0] e);
    reg [7:0] s;
  begin
    s = stolen;
    setAddr(a);
    wr(`FPMA_OFF_CONTROL, 32'h0000_0041);
    rd(`FPMA_OFF_DATA_LOW);
    chk(rdat, {24'h0, e[7:0]});
    rd(`FPMA_OFF_DATA_HIGH);
    chk(rdat, {26'h0, e[13:8]});
    chk(stolen, s + 8'h01);
    rd(`FPMA_OFF_CONTROL);
    chk(rdat[0], 1'b0);
  end
  endtask
  task load(input [7:0] lo, input [7:0] hi);
  begin
    wr(`FPMA_OFF_DATA_LOW, {24'h0, lo});
    wr(`FPMA_OFF_DATA_HIGH, {24'h0, hi});
  end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task tErase;
  begin
    setAddr(13'h0825);
    wr(`FPMA_OFF_CONTROL, 32'h0000_004C);
    waitIdle;
    rdWord(13'h0820, 14'h3FFF);
    rdWord(13'h083F, 14'h3FFF);
  end
  endtask
  task tProgram;
  begin
    setAddr(13'h0825);
    wr(`FPMA_OFF_CONTROL, 32'h0000_0040);
    load(8'h5C, 8'hEA);
    rd(`FPMA_OFF_LATCH_CNT);
    chk(rdat, 32'h0000_0001);
    wr(`FPMA_OFF_ADDR_LOW, 32'h0000_003F);
    load(8'hA3, 8'h15);
    wr(`FPMA_OFF_CONTROL, 32'h0000_004A);
    waitIdle;
    rd(`FPMA_OFF_LATCH_CNT);
    chk(rdat, 32'h0000_0000);
    rdWord(13'h0825, 14'h2A5C);
    rdWord(13'h083F, 14'h15A3);
    rdWord(13'h0824, 14'h3FFF);
    // Partial rewrite: erase the row, restore the saved word, replace the last
    setAddr(13'h0830);
    wr(`FPMA_OFF_CONTROL, 32'h0000_004C);
    waitIdle;
    wr(`FPMA_OFF_ADDR_LOW, 32'h0000_0025);
    load(8'h5C, 8'h2A);
    wr(`FPMA_OFF_ADDR_LOW, 32'h0000_003F);
    load(8'h3C, 8'h01);
    wr(`FPMA_OFF_CONTROL, 32'h0000_004A);
    waitIdle;
    rdWord(13'h0825, 14'h2A5C);
    rdWord(13'h083F, 14'h013C);
  end
  endtask
  task tProtect;
  begin
    writeProtect <= 2'b00;
    wr(`FPMA_OFF_CONTROL, 32'h0000_004C);
    waitIdle;
    rd(`FPMA_OFF_CONTROL);
    chk(rdat[4], 1'b1);
    rdWord(13'h0825, 14'h2A5C);
    wr(`FPMA_OFF_CONTROL, 32'h0000_0040);
    writeProtect <= 2'b10;
    setAddr(13'h0005);
    load(8'h00, 8'h00);
    wr(`FPMA_OFF_CONTROL, 32'h0000_004A);
    waitIdle;
    rd(`FPMA_OFF_CONTROL);
    chk(rdat[4], 1'b1);
    // Lower half protected: an upper-half row may be erased
    writeProtect <= 2'b01;
    setAddr(13'h1005);
    wr(`FPMA_OFF_CONTROL, 32'h0000_004C);
    waitIdle;
    rd(`FPMA_OFF_CONTROL);
    chk(rdat[4], 1'b0);
    rdWord(13'h1005, 14'h3FFF);
    writeProtect <= 2'b11;
    codeProtect <= 1'b1;
    rd(`FPMA_OFF_PROTECT);
    chk(rdat, 32'h0000_0007);
    rdWord(13'h0825, 14'h2A5C);
  end
  endtask
  task tHold;
    reg [7:0] s;
  begin
    wr(`FPMA_OFF_ADDR_LOW, 32'h0000_003F);
    rd(`FPMA_OFF_DATA_LOW);
    chk(rdat, 32'h0000_005C);
    wr(`FPMA_OFF_DATA_LOW, 32'h0000_0011);
    chk(resp, `FPMA_RESP_OKAY);
    s = stolen;
    wr(`FPMA_OFF_CONTROL, 32'h0000_00C1);
    rd(`FPMA_OFF_DATA_LOW);
    chk(rdat, 32'h0000_0011);
    chk(stolen, s);
    rd(8'h40);
    chk(resp, `FPMA_RESP_SLVERR);
    chk(rdat, 32'h0000_0000);
    wr(8'h40, 32'h0000_0000);
    chk(resp, `FPMA_RESP_SLVERR);
  end
  endtask

  // Reset, then run every scenario
  initial
  begin
    failCount = 0;
    nTests = 0;
    reset_n = 1'b0;
    writeProtect = 2'b11;
    codeProtect = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    tErase;
    tProgram;
    tProtect;
    tHold;
    printVerdict;
  end
endmodule // testbench

bind fpma_top fpma_monitor fpma_monitor_i (.ref_clk(ref_clk), .reset_n(reset_n),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .stallCycle_q(stallCycle_q));
